/* logic/clock_safeguard_and_reset_control.sv */
// clock source selection, safeguard filtering, clock division and reset sequencing
// assumes oscillator pins are sampled by aclk, well above either oscillator rate
// Notes on behaviour
// - timer/watchdog tick /12, core machine cycle /13
// - converter tick /6 or /12, software selected
// - instructions last two, four or five machine cycles
// - safeguard on: off bit stops main, aux starts
// - clearing off bit or reset restarts main
// - aux runs one own period after missing edge
// - aux stops once main runs again
// - aux clocks the reset delay until main runs
// - aux clock drives everything normally, only slower
// - safeguard suppresses ticks above maximum rate
// - no safeguard: no filter, limit or aux
// - reset from pin, power-on or watchdog
// - pin accepted in any mode, delayed internally
// - reset held while pin stays low
// - run/wait pin reset: halt, pull-ups, restart main
// - stop pin reset: start oscillator, pull-ups
// - internal reset ends 2048 ticks after release
// - watchdog reset behaves like pin reset
`timescale 1ns/100ps
module clock_safeguard_and_reset_control
   import clock_safeguard_pkg::*;
#(
   parameter int MISS_LIMIT = MISS_LIMIT_CYCLES,
   parameter int START_CNT  = START_EDGES,
   parameter int SPIKE_GAP  = SPIKE_GAP_CYCLES
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [11:0] awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [11:0] araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   input  wire logic        main_osc_pin,
   input  wire logic        aux_osc_pin,
   input  wire logic        reset_pin_n,
   input  wire logic        power_on_detect,
   input  wire logic        osc_safeguard,
   input  wire logic        watchdog_timeout,
   input  wire logic        stop_mode,
   input  wire logic [1:0]  instr_len,
   output logic             main_osc_enable,
   output logic             aux_osc_enable,
   output logic             int_tick,
   output logic             timer_tick,
   output logic             cpu_tick,
   output logic             adc_tick,
   output logic             instr_end,
   output logic             internal_reset,
   output logic             io_pullup_in
);
   localparam int GAP_W = 8;

   function automatic logic [9:0] reg_index(input logic [11:0] addr);
      reg_index = addr[11:2];
   endfunction

   function automatic logic [2:0] instr_cycles(input logic [1:0] code);
      if (code == INSTR_LEN_2)
         instr_cycles = 3'h2;
      else if (code == INSTR_LEN_4)
         instr_cycles = 3'h4;
      else
         instr_cycles = 3'h5;
   endfunction

   logic [1:0]             main_sync;
   logic [1:0]             aux_sync;
   logic [1:0]             rst_sync;
   logic [1:0]             por_sync;
   logic [1:0]             sg_sync;
   logic                   main_prev;
   logic                   aux_prev;
   logic                   main_edge;
   logic                   aux_edge;
   logic                   sg;
   logic [7:0]             oscillator_control_reg;
   logic [7:0]             clock_config;
   logic [7:0]             miss_cnt;
   logic                   main_missing;
   logic [7:0]             good_cnt;
   logic                   main_stable;
   aux_state_t             aux_state;
   logic                   raw_tick;
   logic [GAP_W-1:0]       gap_cnt;
   logic                   next_tick;
   logic                   rst_req;
   logic [RESET_CNT_W-1:0] delay_cnt;
   logic [2:0]             mc_cnt;
   logic                   timer_div_pulse;
   logic                   cpu_div_pulse;
   logic                   adc_div_pulse;
   logic [3:0]             adc_ratio;
   logic [7:0]             status;

   // pins pass two flops before anything looks at them
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         main_sync <= 2'h0;
         aux_sync  <= 2'h0;
         rst_sync  <= 2'h0;
         por_sync  <= 2'h0;
         sg_sync   <= 2'h0;
         main_prev <= 1'b0;
         aux_prev  <= 1'b0;
      end else begin
         main_sync <= {main_sync[0], main_osc_pin};
         aux_sync  <= {aux_sync[0], aux_osc_pin};
         rst_sync  <= {rst_sync[0], reset_pin_n};
         por_sync  <= {por_sync[0], power_on_detect};
         sg_sync   <= {sg_sync[0], osc_safeguard};
         main_prev <= main_sync[1];
         aux_prev  <= aux_sync[1];
      end
   end

   assign main_edge = main_sync[1] & ~main_prev;
   assign aux_edge  = aux_sync[1] & ~aux_prev;
   assign sg        = sg_sync[1];

   // missing-edge watch: a silent main line for MISS_LIMIT cycles counts as failed
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         miss_cnt <= 8'h0;
      end else if (main_edge) begin
         miss_cnt <= 8'h0;
      end else if (!main_missing) begin
         miss_cnt <= miss_cnt + 8'h1;
      end
   end
   assign main_missing = (miss_cnt >= 8'(MISS_LIMIT));

   // main counts as running again only after a start-up run of edges
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         good_cnt <= 8'h0;
      end else if (main_missing || !main_osc_enable) begin
         good_cnt <= 8'h0;
      end else if (main_edge && !main_stable) begin
         good_cnt <= good_cnt + 8'h1;
      end
   end
   assign main_stable = (good_cnt >= 8'(START_CNT));

   // the oscillator always runs in reset, even out of stop
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         main_osc_enable <= 1'b1;
      end else begin
         main_osc_enable <= internal_reset ||
                            (!stop_mode && !(sg && oscillator_control_reg[OSC_OFF_BIT]));
      end
   end

   // aux source sequencing; with the safeguard on, changes of source happen only on an edge of the
   // source being switched to, so no short pulse reaches the dividers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aux_state <= AUX_IDLE;
      end else begin
         case (aux_state)
            AUX_IDLE: begin
               if (sg && (main_missing || !main_osc_enable))
                  aux_state <= AUX_WAIT;
            end
            AUX_WAIT: begin
               if (!sg)
                  aux_state <= AUX_IDLE;
               else if (aux_edge)
                  aux_state <= AUX_RUN;
            end
            AUX_RUN: begin
               if (!sg)
                  aux_state <= AUX_IDLE;
               else if (main_stable && main_edge && main_osc_enable)
                  aux_state <= AUX_IDLE;
            end
            default: aux_state <= AUX_IDLE;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aux_osc_enable <= 1'b0;
      end else begin
         aux_osc_enable <= sg && (aux_state != AUX_IDLE) && !(aux_state == AUX_RUN && main_stable && main_edge);
      end
   end

   // aux ticks feed the same dividers, so core and reset delay just run slower
   assign raw_tick = (aux_state == AUX_RUN) ? aux_edge : main_edge;

   // spike filter: ticks closer than SPIKE_GAP cycles are dropped
   assign next_tick = raw_tick && (!sg || gap_cnt >= GAP_W'(SPIKE_GAP - 1));

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gap_cnt <= '0;
      end else if (next_tick) begin
         gap_cnt <= '0;
      end else if (gap_cnt != {GAP_W{1'b1}}) begin
         gap_cnt <= gap_cnt + GAP_W'(1);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn)
         int_tick <= 1'b0;
      else
         int_tick <= next_tick;
   end

   assign adc_ratio = clock_config[ADC_SLOW_BIT] ? 4'(ADC_DIV_SLOW) : 4'(ADC_DIV_FAST);

   clock_tick_divider #(.WIDTH(4)) timer_div (
      .aclk    (aclk),
      .aresetn (aresetn),
      .tick    (next_tick),
      .ratio   (4'(TIMER_DIV)),
      .pulse   (timer_div_pulse)
   );

   clock_tick_divider #(.WIDTH(4)) cpu_div (
      .aclk    (aclk),
      .aresetn (aresetn),
      .tick    (next_tick),
      .ratio   (4'(CPU_DIV)),
      .pulse   (cpu_div_pulse)
   );

   clock_tick_divider #(.WIDTH(4)) adc_div (
      .aclk    (aclk),
      .aresetn (aresetn),
      .tick    (next_tick),
      .ratio   (adc_ratio),
      .pulse   (adc_div_pulse)
   );

   assign timer_tick = timer_div_pulse;
   assign cpu_tick   = cpu_div_pulse;
   assign adc_tick   = adc_div_pulse;

   // machine cycles per instruction; the core holds instr_len for the instruction
   always_ff @(posedge aclk) begin
      if (!aresetn || internal_reset) begin
         mc_cnt    <= 3'h0;
         instr_end <= 1'b0;
      end else begin
         instr_end <= 1'b0;
         if (cpu_div_pulse) begin
            if (mc_cnt >= instr_cycles(instr_len) - 3'h1) begin
               mc_cnt    <= 3'h0;
               instr_end <= 1'b1;
            end else begin
               mc_cnt <= mc_cnt + 3'h1;
            end
         end
      end
   end

   // every source reloads the same delay; a short pin pulse still runs the full count
   assign rst_req = !rst_sync[1] || por_sync[1] || watchdog_timeout;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         internal_reset <= 1'b1;
         delay_cnt      <= '0;
      end else if (rst_req) begin
         internal_reset <= 1'b1;
         delay_cnt      <= '0;
      end else if (internal_reset && next_tick) begin
         if (delay_cnt == RESET_CNT_W'(RESET_DELAY_TICKS - 1)) begin
            internal_reset <= 1'b0;
         end else begin
            delay_cnt <= delay_cnt + RESET_CNT_W'(1);
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn)
         io_pullup_in <= 1'b1;
      else
         io_pullup_in <= internal_reset || rst_req;
   end

   assign status = {3'h0, internal_reset, sg, main_missing, main_stable, aux_state == AUX_RUN};

   // AXI4-Lite write: address and data are taken together, then a response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b0;
         wready  <= 1'b0;
         bvalid  <= 1'b0;
         bresp   <= RESP_OKAY;
      end else begin
         awready <= 1'b0;
         wready  <= 1'b0;
         if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
         if (awvalid && wvalid && !bvalid && !awready) begin
            awready <= 1'b1;
            wready  <= 1'b1;
         end
         if (awready) begin
            bvalid <= 1'b1;
            bresp  <= (reg_index(awaddr) == OSC_CTRL_INDEX || reg_index(awaddr) == CLK_CFG_INDEX ||
                       reg_index(awaddr) == STATUS_INDEX) ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   // only bit 0 is stored; upper bits read zero; any reset restarts the main oscillator
   always_ff @(posedge aclk) begin
      if (!aresetn || internal_reset) begin
         oscillator_control_reg <= OSC_CTRL_RESET;
      end else if (awready && wstrb[0] && reg_index(awaddr) == OSC_CTRL_INDEX) begin
         oscillator_control_reg <= {7'h0, wdata[OSC_OFF_BIT]};
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clock_config <= CLK_CFG_RESET;
      end else if (awready && wstrb[0] && reg_index(awaddr) == CLK_CFG_INDEX) begin
         clock_config <= {7'h0, wdata[ADC_SLOW_BIT]};
      end
   end

   // AXI4-Lite read
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= 32'h0;
         rresp   <= RESP_OKAY;
      end else begin
         arready <= 1'b0;
         if (rvalid && rready) begin
            rvalid <= 1'b0;
         end
         if (arvalid && !rvalid && !arready) begin
            arready <= 1'b1;
         end
         if (arready) begin
            rvalid <= 1'b1;
            rresp  <= RESP_OKAY;
            case (reg_index(araddr))
               OSC_CTRL_INDEX: rdata <= {24'h0, oscillator_control_reg};
               CLK_CFG_INDEX:  rdata <= {24'h0, clock_config};
               STATUS_INDEX:   rdata <= {24'h0, status};
               default: begin
                  rdata <= 32'h0;
                  rresp <= RESP_SLVERR;
               end
            endcase
         end
      end
   end

   // helper counters for the checks below
   logic [3:0]             h_timer;
   logic [3:0]             h_cpu;
   logic [RESET_CNT_W-1:0] h_rst;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         h_timer <= 4'h0;
         h_cpu   <= 4'h0;
         h_rst   <= '0;
      end else begin
         if (timer_tick)
            h_timer <= 4'h0;
         else if (int_tick)
            h_timer <= h_timer + 4'h1;
         if (cpu_tick)
            h_cpu <= 4'h0;
         else if (int_tick)
            h_cpu <= h_cpu + 4'h1;
         if (rst_req)
            h_rst <= '0;
         else if (internal_reset && next_tick)
            h_rst <= h_rst + RESET_CNT_W'(1);
      end
   end

   sequence aux_arms;
      aux_state == AUX_WAIT && sg && aux_edge;
   endsequence

   sequence aux_returns;
      aux_state == AUX_RUN && sg && main_stable && main_edge && main_osc_enable;
   endsequence

   a_timer_ratio: assert property (@(posedge aclk) disable iff (!aresetn)
      timer_tick |-> int_tick && h_timer == 4'(TIMER_DIV - 1)) else $error("timer tick spacing wrong");
   a_cpu_ratio: assert property (@(posedge aclk) disable iff (!aresetn)
      cpu_tick |-> int_tick && h_cpu == 4'(CPU_DIV - 1)) else $error("core tick spacing wrong");
   a_adc_on_tick: assert property (@(posedge aclk) disable iff (!aresetn)
      adc_tick |-> int_tick) else $error("converter tick off the internal clock");
   a_osc_off_stops: assert property (@(posedge aclk) disable iff (!aresetn)
      (sg && oscillator_control_reg[OSC_OFF_BIT] && !internal_reset) |=> !main_osc_enable)
      else $error("main oscillator not stopped");
   a_reset_restarts: assert property (@(posedge aclk) disable iff (!aresetn)
      internal_reset |=> main_osc_enable ##1 oscillator_control_reg == OSC_CTRL_RESET)
      else $error("reset did not restart main oscillator");
   a_aux_start: assert property (@(posedge aclk) disable iff (!aresetn)
      aux_arms |=> aux_state == AUX_RUN) else $error("aux not selected after its period");
   a_aux_release: assert property (@(posedge aclk) disable iff (!aresetn)
      aux_returns |=> aux_state == AUX_IDLE && !aux_osc_enable) else $error("aux not released");
   a_no_sg_aux: assert property (@(posedge aclk) disable iff (!aresetn)
      !sg [*2] |=> !aux_osc_enable && aux_state == AUX_IDLE) else $error("aux active without safeguard");
   a_spike_gap: assert property (@(posedge aclk) disable iff (!aresetn)
      (int_tick && sg) ##1 sg [*3] |-> !int_tick && !$past(int_tick) && !$past(int_tick, 2))
      else $error("ticks closer than the safeguard gap");
   a_reset_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      !rst_sync[1] |=> internal_reset) else $error("reset released with pin low");
   a_reset_delay: assert property (@(posedge aclk) disable iff (!aresetn)
      $fell(internal_reset) |-> h_rst == RESET_CNT_W'(RESET_DELAY_TICKS)) else $error("reset delay not 2048 ticks");
   a_wdog_reset: assert property (@(posedge aclk) disable iff (!aresetn)
      watchdog_timeout |=> internal_reset && delay_cnt == '0 ##1 io_pullup_in)
      else $error("watchdog did not restart the delay");
endmodule

/* shared/clock_safeguard_pkg.sv */
// constants, register map and types shared by the clock safeguard and reset control block
// assumes a 10 MHz aclk; registers sit on an AXI4-Lite slave, one 32-bit word each
package clock_safeguard_pkg;

   // internal clock division ratios
   localparam int TIMER_DIV          = 12;
   localparam int CPU_DIV            = 13;
   localparam int ADC_DIV_FAST       = 6;
   localparam int ADC_DIV_SLOW       = 12;

   // internal reset release delay, in internal clock ticks
   localparam int RESET_DELAY_TICKS  = 2048;
   localparam int RESET_CNT_W        = 12;

   // oscillator supervision defaults, in aclk cycles or main edges
   localparam int MISS_LIMIT_CYCLES  = 16;
   localparam int START_EDGES        = 64;
   localparam int SPIKE_GAP_CYCLES   = 4;

   // register indices; byte address is four times the index
   localparam logic [9:0] OSC_CTRL_INDEX = 10'h0db;
   localparam logic [9:0] CLK_CFG_INDEX  = 10'h0f0;
   localparam logic [9:0] STATUS_INDEX   = 10'h0f1;

   // field positions
   localparam int OSC_OFF_BIT          = 0;
   localparam int ADC_SLOW_BIT         = 0;
   localparam int STAT_AUX_SEL_BIT     = 0;
   localparam int STAT_MAIN_STABLE_BIT = 1;
   localparam int STAT_MAIN_MISS_BIT   = 2;
   localparam int STAT_SAFEGUARD_BIT   = 3;
   localparam int STAT_RESET_BIT       = 4;

   // reset values
   localparam logic [7:0] OSC_CTRL_RESET = 8'h00;
   localparam logic [7:0] CLK_CFG_RESET  = 8'h00;

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // instruction length codes from the core
   localparam logic [1:0] INSTR_LEN_2 = 2'h0;
   localparam logic [1:0] INSTR_LEN_4 = 2'h1;

   typedef enum logic [1:0] {
      AUX_IDLE = 2'b00,
      AUX_WAIT = 2'b01,
      AUX_RUN  = 2'b10
   } aux_state_t;

endpackage

/* logic/clock_tick_divider.sv */
// divides a stream of one-cycle internal clock ticks by a run-time ratio
// assumes tick is a one-cycle pulse on aclk; pulse is registered
`timescale 1ns/100ps
module clock_tick_divider #(
   parameter int WIDTH = 4
) (
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic             tick,
   input  wire logic [WIDTH-1:0] ratio,
   output logic                  pulse
);
   logic [WIDTH-1:0] count;

   // ">=" lets a ratio lowered mid-count wrap at once instead of running to overflow
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count <= '0;
         pulse <= 1'b0;
      end else begin
         pulse <= 1'b0;
         if (tick) begin
            if (count >= ratio - WIDTH'(1)) begin
               count <= '0;
               pulse <= 1'b1;
            end else begin
               count <= count + WIDTH'(1);
            end
         end
      end
   end
endmodule

/* sim/osc_partner.sv */
// oscillator pads seen by the clock block: main crystal and low-frequency aux oscillator
// assumes aclk runs far above both; a stopped oscillator rests low
`timescale 1ns/100ps
module osc_partner (
   input  wire logic       aclk,
   input  wire logic       main_osc_enable,
   input  wire logic       aux_osc_enable,
   input  wire logic       main_run,
   input  wire logic [3:0] main_half,
   output logic            main_osc_pin,
   output logic            aux_osc_pin
);
   logic [3:0] mcnt = 4'h0;
   logic [3:0] acnt = 4'h0;
   initial main_osc_pin = 1'b0;
   initial aux_osc_pin = 1'b0;
   // main_run low models a failed crystal even while enabled
   always @(posedge aclk) begin
      mcnt <= (main_osc_enable && main_run && mcnt < main_half - 4'h1) ? mcnt + 4'h1 : 4'h0;
      if (!(main_osc_enable && main_run)) begin
         main_osc_pin <= 1'b0;
      end else if (mcnt == main_half - 4'h1) begin
         main_osc_pin <= ~main_osc_pin;
      end
   end
   // aux is slower than main so a switch to it shows in the tick spacing
   always @(posedge aclk) begin
      acnt <= (aux_osc_enable && acnt < 4'h9) ? acnt + 4'h1 : 4'h0;
      if (!aux_osc_enable) begin
         aux_osc_pin <= 1'b0;
      end else if (acnt == 4'h9) begin
         aux_osc_pin <= ~aux_osc_pin;
      end
   end
endmodule

/* sim/tb.sv */
// self-checking bench for the clock safeguard and reset control block
// assumes the oscillator partner model and the package; AXI4-Lite master tasks
`timescale 1ns/100ps
module tb;
   import clock_safeguard_pkg::*;
   localparam int SG = 6;
   localparam logic [11:0] A_OSC = {OSC_CTRL_INDEX, 2'h0};
   localparam logic [11:0] A_CFG = {CLK_CFG_INDEX, 2'h0};
   localparam logic [11:0] A_STAT = {STATUS_INDEX, 2'h0};
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
   logic        arready, rvalid, main_osc_pin, aux_osc_pin, reset_pin_n, power_on_detect, osc_safeguard;
   logic        watchdog_timeout, stop_mode, main_run, main_osc_enable, aux_osc_enable, int_tick;
   logic        timer_tick, cpu_tick, adc_tick, instr_end, internal_reset, io_pullup_in;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [3:0]  wstrb, main_half;
   logic [1:0]  bresp, rresp, instr_len, rs;
   int          failures, tests_run, n_tim, n_cpu, n_adc, n_ins, g_tim, g_cpu, g_adc, g_ins;
   int          n_rst, since, mingap;

   clock_safeguard_and_reset_control #(.MISS_LIMIT(MISS_LIMIT_CYCLES), .START_CNT(4), .SPIKE_GAP(SG)) dut_u (.*);
   osc_partner osc_u (.*);

   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end

   // spacing of divided pulses, counted in the ticks that feed them
   always @(posedge aclk) begin
      since++;
      if (int_tick) begin
         n_tim++;
         n_cpu++;
         n_adc++;
         n_rst += internal_reset;
         mingap = (since < mingap) ? since : mingap;
         since = 0;
      end
      n_ins += cpu_tick;
      if (timer_tick) begin
         g_tim = n_tim;
         n_tim = 0;
      end
      if (cpu_tick) begin
         g_cpu = n_cpu;
         n_cpu = 0;
      end
      if (adc_tick) begin
         g_adc = n_adc;
         n_adc = 0;
      end
      if (instr_end) begin
         g_ins = n_ins;
         n_ins = 0;
      end
   end

   task give_verdict;
      $display("failures %0d tests_run %0d", failures, tests_run);
      if (failures == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask

   // sel 0 internal_reset, 1 aux enable, 2 main enable
   task wait_for(input int sel, input logic val, input int lim);
      logic [2:0] m;
      for (int i = 0; i <= lim; i++) begin
         @(negedge aclk);
         m = {main_osc_enable, aux_osc_enable, internal_reset};
         if (m[sel] === val) return;
      end
      failures++;
      give_verdict;
   endtask

   // sel 0 aw and w taken, 1 bvalid, 2 arready, 3 rvalid
   task wait_hs(input int sel);
      logic [3:0] h;
      for (int i = 0; i < 50; i++) begin
         @(posedge aclk);
         h = {rvalid, arready, bvalid, awready & wready};
         if (h[sel] === 1'b1) return;
      end
      failures++;
      give_verdict;
   endtask

   task axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      wait_hs(0);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      wait_hs(1);
      r = bresp;
      bready <= 1'b0;
   endtask

   task axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      wait_hs(2);
      arvalid <= 1'b0;
      wait_hs(3);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask

   // the pin sync costs a tick or so either side of the nominal count
   task rst_count;
      n_rst = 0;
      wait_for(0, 1'b0, 20000);
      check(n_rst >= 2047 && n_rst <= 2050, 1);
   endtask

   initial begin
      {awvalid, wvalid, bready, arvalid, rready, power_on_detect, osc_safeguard} = '0;
      {watchdog_timeout, stop_mode, instr_len, awaddr, araddr, wdata, wstrb} = '0;
      {aresetn, reset_pin_n, main_run, main_half, mingap} = {3'b011, 4'h3, 32'd999};
      cyc(12);
      aresetn <= 1'b1;
      @(negedge aclk);
      check(internal_reset, 1);
      check(io_pullup_in, 1);
      check(main_osc_enable, 1);
      rst_count;
      axi_rd(A_OSC, rd, rs);
      check(rd, 0);
      check(rs, RESP_OKAY);
      axi_rd(12'h004, rd, rs);
      check(rs, RESP_SLVERR);
      check(rd, 32'h0);
      axi_wr(12'h004, 32'h1, rs);
      check(rs, RESP_SLVERR);
      cyc(400);
      check(g_tim, TIMER_DIV);
      check(g_cpu, CPU_DIV);
      check(g_adc, ADC_DIV_FAST);
      axi_wr(A_CFG, 32'h1, rs);
      cyc(200);
      check(g_adc, ADC_DIV_SLOW);
      for (int c = 0; c < 4; c++) begin
         instr_len <= c[1:0];
         cyc(1300);
         check(g_ins, c == 0 ? 2 : c == 1 ? 4 : 5);
      end
      reset_pin_n <= 1'b0;
      cyc(2);
      reset_pin_n <= 1'b1;
      wait_for(0, 1'b1, 10);
      check(io_pullup_in, 1);
      rst_count;
      @(posedge aclk);
      stop_mode <= 1'b1;
      wait_for(2, 1'b0, 10);
      @(posedge aclk);
      reset_pin_n <= 1'b0;
      cyc(40);
      @(negedge aclk);
      check(internal_reset, 1);
      check({main_osc_enable, io_pullup_in}, 2'b11);
      @(posedge aclk);
      stop_mode <= 1'b0;
      reset_pin_n <= 1'b1;
      rst_count;
      @(posedge aclk);
      watchdog_timeout <= 1'b1;
      @(posedge aclk);
      watchdog_timeout <= 1'b0;
      wait_for(0, 1'b1, 10);
      rst_count;
      @(posedge aclk);
      power_on_detect <= 1'b1;
      cyc(3);
      power_on_detect <= 1'b0;
      wait_for(0, 1'b1, 10);
      rst_count;
      axi_wr(A_OSC, 32'h1, rs);
      cyc(30);
      @(negedge aclk);
      check({main_osc_enable, aux_osc_enable}, 2'b10);
      axi_wr(A_OSC, 32'h0, rs);
      main_half <= 4'h2;
      cyc(20);
      @(negedge aclk);
      mingap = 999;
      cyc(200);
      @(negedge aclk);
      check(mingap, 4);
      osc_safeguard <= 1'b1;
      cyc(20);
      @(negedge aclk);
      mingap = 999;
      cyc(200);
      @(negedge aclk);
      check(mingap >= SG, 1);
      g_tim = 0;
      @(posedge aclk);
      main_half <= 4'h3;
      main_run <= 1'b0;
      wait_for(1, 1'b1, MISS_LIMIT_CYCLES + 10);
      mingap = 999;
      cyc(600);
      check(g_tim, TIMER_DIV);
      check(mingap, 20);
      axi_rd(A_STAT, rd, rs);
      check(rd, (1 << STAT_AUX_SEL_BIT) | (1 << STAT_MAIN_MISS_BIT) | (1 << STAT_SAFEGUARD_BIT));
      main_run <= 1'b1;
      wait_for(1, 1'b0, 600);
      axi_wr(A_OSC, 32'h1, rs);
      wait_for(2, 1'b0, 10);
      wait_for(1, 1'b1, 40);
      axi_wr(A_OSC, 32'h0, rs);
      wait_for(2, 1'b1, 10);
      wait_for(1, 1'b0, 600);
      give_verdict;
   end
endmodule
